/* sqi_map.vh */
// constants of the settings query interpreter: offsets, fields, codes, resets
// assumes a 100 MHz clock and a single AHB-Lite master
// Notes on behaviour
// - a command with the get flag replies the setting's value and changes nothing
// - the help-list command replies every query opcode but its own, 1 to 17, one word each
// - analog offset query: tap 0 gives all taps, 1 to 4 one tap
// - fixed-pattern range query returns each coefficient from start to end pixel
// - response-nonuniformity range query returns each gain coefficient in range
// - line-end statistics query returns 0 when off, 1 when on
// - coefficient-enable query returns fixed-pattern enable, then nonuniformity enable
// - frequency query takes selector 1 to 4 and returns that line's frequency
// - total gain per tap is user gain plus reference, and drives the gain used
// - sample-count query returns the lines averaged for coefficients and averages
// - averaged-pixel query returns the mean of pixel values over the range
// - pixel-value query returns the raw pixel values over the range
// - single coefficient query returns one pixel's fixed-pattern coefficient
// - three identity queries return model number, serial number, version
// - both corrections have own enables, set by one coefficient-enable command
// - link-mode query returns mode, class, taps, bit depth and time multiplexing
// - sample count takes only 256, 512 or 1024, reset value 1024
// - selector 1 is line sync, 2 and 4 spare, 3 forward direction
`ifndef SQI_MAP_VH
`define SQI_MAP_VH
// register byte offsets
`define SQI_OFS_CMD 8'h00
`define SQI_OFS_ARG1 8'h04
`define SQI_OFS_ARG2 8'h08
`define SQI_OFS_STAT 8'h0c
`define SQI_OFS_REPLY 8'h10
// command word fields
`define SQI_CMD_GET 8
`define SQI_CMD_NA 9
// status bits
`define SQI_ST_BUSY 0
`define SQI_ST_ERR 1
`define SQI_ST_VALID 2
`define SQI_ST_DONE 3
// opcodes
`define SQI_OP_AOFS 8'h01
`define SQI_OP_FPRNG 8'h02
`define SQI_OP_RNRNG 8'h03
`define SQI_OP_LINK 8'h04
`define SQI_OP_SAMP 8'h05
`define SQI_OP_EOLS 8'h06
`define SQI_OP_CEN 8'h07
`define SQI_OP_MODEL 8'h08
`define SQI_OP_SERIAL 8'h09
`define SQI_OP_VER 8'h0a
`define SQI_OP_FPONE 8'h0b
`define SQI_OP_PIXV 8'h0c
`define SQI_OP_PIXAVG 8'h0d
`define SQI_OP_FREQ 8'h0e
`define SQI_OP_GAIN 8'h0f
`define SQI_OP_GREF 8'h10
`define SQI_OP_TGAIN 8'h11
`define SQI_OP_HELP 8'h12
`define SQI_HELP_N 16'h0011
// pixel source select
`define SQI_SEL_RAW 2'h0
`define SQI_SEL_FP 2'h1
`define SQI_SEL_RN 2'h2
// reset values and legal sample counts
`define SQI_SAMP_RST 11'h400
`define SQI_SAMP_A 11'h100
`define SQI_SAMP_B 11'h200
`define SQI_SET_RST 16'h0000
// link mode word: mode 15, class medium, 4 taps, 8 bits, no mux
`define SQI_LINK_WORD 32'h0f14_0800
// timing
`define SQI_CLK_MHZ 100
`define SQI_GATE_US 1000
`define SQI_GATE_CYC (`SQI_GATE_US * `SQI_CLK_MHZ)
`define SQI_HZ_SCALE 32'd1000
`endif

/* sqi_top.v */
// settings query interpreter: command decode, reply sequencing, frequency gauge
// assumes an AHB-Lite master and a pixel source answering in the read cycle
`include "sqi_map.vh"

module sqi_top #(
  parameter [31:0] GATE_CYC = `SQI_GATE_CYC,
  parameter [31:0] MODEL_ID = 32'h0000_0a01, // arbitrary value
  parameter [31:0] SERIAL_ID = 32'h0000_0b02, // arbitrary value
  parameter [31:0] VERSION_ID = 32'h0000_0c03 // arbitrary value
)(
  // clock and reset
  input wire clk,
  input wire resetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // control lines: sync, spare, forward, spare
  input wire [3:0] ctl_line,
  // pixel source port
  output reg pix_rd,
  output reg [1:0] pix_sel,
  output reg [12:0] pix_addr,
  input wire [15:0] pix_data,
  // settings in use
  output reg fixed_pattern_correction_en,
  output reg response_nonuniformity_correction_en,
  output reg eol_stats_en,
  output reg [10:0] line_samples,
  output reg [63:0] analog_offset,
  output reg [63:0] gain_total
);

  // ==========================================
  // states
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_CHK = 6'h02;
  localparam [5:0] S_RD = 6'h04;
  localparam [5:0] S_WT = 6'h08;
  localparam [5:0] S_PUT = 6'h10;
  localparam [5:0] S_DIV = 6'h20;

  // ==========================================
  // decode helpers
  function [1:0] op_args;
    input [7:0] op;
    begin
      case (op)
        `SQI_OP_FPRNG, `SQI_OP_RNRNG, `SQI_OP_PIXV, `SQI_OP_PIXAVG: op_args = 2'h2;
        `SQI_OP_AOFS, `SQI_OP_GAIN, `SQI_OP_TGAIN, `SQI_OP_FREQ, `SQI_OP_FPONE: op_args = 2'h1;
        default: op_args = 2'h0;
      endcase
    end
  endfunction

  function is_pix;
    input [7:0] op;
    begin
      case (op)
        `SQI_OP_FPRNG, `SQI_OP_RNRNG, `SQI_OP_PIXV, `SQI_OP_PIXAVG, `SQI_OP_FPONE: is_pix = 1'b1;
        default: is_pix = 1'b0;
      endcase
    end
  endfunction

  function is_tap;
    input [7:0] op;
    begin
      is_tap = (op == `SQI_OP_AOFS) | (op == `SQI_OP_GAIN) | (op == `SQI_OP_TGAIN);
    end
  endfunction

  // ==========================================
  // state and settings
  reg [5:0] state_r;
  reg [7:0] op_r;
  reg get_r;
  reg [1:0] na_r;
  reg [15:0] a1_r;
  reg [15:0] a2_r;
  reg [15:0] idx_r;
  reg [15:0] cnt_r;
  reg [15:0] cur_r;
  reg [15:0] last_r;
  reg [31:0] sum_r;
  reg [31:0] rem_r;
  reg [15:0] n_r;
  reg [5:0] dcnt_r;
  reg [31:0] reply_r;
  reg err_r;
  reg done_r;
  reg [63:0] gain_r;
  reg [15:0] gref_r;
  reg [31:0] win_r;
  reg wr_r;
  reg [7:0] wa_r;

  wire acc = hsel & htrans[1] & hready;
  wire pop = acc & ~hwrite & (haddr[7:0] == `SQI_OFS_REPLY) & state_r[4];
  wire tick = (win_r == GATE_CYC - 32'h1);
  wire [63:0] freq_w;
  wire [63:0] tsum_w;

  // ==========================================
  // control line frequency gauge
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_line
      reg [2:0] sh_r;
      reg lvl_r;
      reg [15:0] ec_r;
      reg [15:0] fq_r;
      wire rise = (sh_r[1] == sh_r[2]) & sh_r[1] & ~lvl_r;
      always @(posedge clk)
      begin
        if (!resetn)
        begin
          sh_r <= 3'h0;
          lvl_r <= 1'b0;
          ec_r <= 16'h0;
          fq_r <= 16'h0;
        end
        else
        begin
          sh_r <= {sh_r[1:0], ctl_line[gi]};
          if (sh_r[1] == sh_r[2])
            lvl_r <= sh_r[1];
          if (tick)
          begin
            fq_r <= ec_r + {15'h0, rise};
            ec_r <= 16'h0;
          end
          else
            ec_r <= ec_r + {15'h0, rise};
        end
      end
      assign freq_w[gi*16 +: 16] = fq_r;
      assign tsum_w[gi*16 +: 16] = gain_r[gi*16 +: 16] + gref_r;
    end
  endgenerate

  // ==========================================
  // reply word for the current list position
  reg [15:0] widx;
  reg [1:0] tap;
  reg [1:0] fsel;
  reg [31:0] word;
  reg [15:0] nwords;
  reg err_w;
  always @*
  begin
    widx = state_r[1] ? 16'h0 : idx_r + 16'h1;
    tap = (a1_r == 16'h0) ? widx[1:0] : a1_r[1:0] - 2'h1;
    fsel = a1_r[1:0] - 2'h1;
    word = 32'h0;
    nwords = 16'h1;
    case (op_r)
      `SQI_OP_AOFS: word = {16'h0, analog_offset[{tap, 4'h0} +: 16]};
      `SQI_OP_GAIN: word = {16'h0, gain_r[{tap, 4'h0} +: 16]};
      `SQI_OP_TGAIN: word = {16'h0, gain_total[{tap, 4'h0} +: 16]};
      `SQI_OP_GREF: word = {16'h0, gref_r};
      `SQI_OP_LINK: word = `SQI_LINK_WORD;
      `SQI_OP_SAMP: word = {21'h0, line_samples};
      `SQI_OP_EOLS: word = {31'h0, eol_stats_en};
      `SQI_OP_CEN: word = {31'h0, widx[0] ? response_nonuniformity_correction_en
                                             : fixed_pattern_correction_en};
      `SQI_OP_MODEL: word = MODEL_ID;
      `SQI_OP_SERIAL: word = SERIAL_ID;
      `SQI_OP_VER: word = VERSION_ID;
      `SQI_OP_FREQ: word = {16'h0, freq_w[{fsel, 4'h0} +: 16]} * `SQI_HZ_SCALE;
      `SQI_OP_HELP: word = {24'h0, widx[7:0] + 8'h1};
      default: word = 32'h0;
    endcase
    if (is_tap(op_r) && a1_r == 16'h0)
      nwords = 16'h4;
    else if (op_r == `SQI_OP_CEN)
      nwords = 16'h2;
    else if (op_r == `SQI_OP_HELP)
      nwords = `SQI_HELP_N;
    // argument and opcode checks
    err_w = (op_r == 8'h0) | (op_r > `SQI_OP_HELP);
    if (get_r)
    begin
      if (na_r < op_args(op_r))
        err_w = 1'b1;
      if (is_tap(op_r) && a1_r > 16'h4)
        err_w = 1'b1;
      if (op_r == `SQI_OP_FREQ && (a1_r == 16'h0 || a1_r > 16'h4))
        err_w = 1'b1;
      if (is_pix(op_r) && a1_r == 16'h0)
        err_w = 1'b1;
    end
    else
    begin
      case (op_r)
        `SQI_OP_AOFS, `SQI_OP_GAIN: err_w = (na_r < 2'h2) | (a1_r > 16'h4);
        `SQI_OP_CEN: err_w = (na_r < 2'h2);
        `SQI_OP_GREF, `SQI_OP_EOLS: err_w = (na_r == 2'h0);
        `SQI_OP_SAMP: err_w = (na_r == 2'h0) | ~((a1_r == {5'h0, `SQI_SAMP_A}) |
                              (a1_r == {5'h0, `SQI_SAMP_B}) | (a1_r == {5'h0, `SQI_SAMP_RST}));
        default: err_w = 1'b1;
      endcase
    end
  end

  wire [31:0] rem2 = {rem_r[30:0], sum_r[31]};
  wire ge = (rem2 >= {16'h0, n_r});

  // ==========================================
  // bus slave and sequencer
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_r <= 1'b0;
      wa_r <= 8'h0;
      state_r <= S_IDLE;
      op_r <= 8'h0;
      get_r <= 1'b0;
      na_r <= 2'h0;
      a1_r <= 16'h0;
      a2_r <= 16'h0;
      idx_r <= 16'h0;
      cnt_r <= 16'h0;
      cur_r <= 16'h0;
      last_r <= 16'h0;
      sum_r <= 32'h0;
      rem_r <= 32'h0;
      n_r <= 16'h0;
      dcnt_r <= 6'h0;
      reply_r <= 32'h0;
      err_r <= 1'b0;
      done_r <= 1'b0;
      pix_rd <= 1'b0;
      pix_sel <= `SQI_SEL_RAW;
      pix_addr <= 13'h0;
      fixed_pattern_correction_en <= 1'b0;
      response_nonuniformity_correction_en <= 1'b0;
      eol_stats_en <= 1'b0;
      line_samples <= `SQI_SAMP_RST;
      analog_offset <= {4{`SQI_SET_RST}};
      gain_r <= {4{`SQI_SET_RST}};
      gref_r <= `SQI_SET_RST;
      gain_total <= {4{`SQI_SET_RST}};
      win_r <= 32'h0;
    end
    else
    begin
      win_r <= tick ? 32'h0 : win_r + 32'h1;
      gain_total <= tsum_w;
      pix_rd <= 1'b0;
      wr_r <= acc & hwrite;
      wa_r <= haddr[7:0];
      if (acc & ~hwrite)
      begin
        case (haddr[7:0])
          `SQI_OFS_ARG1: hrdata <= {16'h0, a1_r};
          `SQI_OFS_ARG2: hrdata <= {16'h0, a2_r};
          `SQI_OFS_STAT: hrdata <= {28'h0, done_r, state_r[4], err_r, ~state_r[0]};
          `SQI_OFS_REPLY: hrdata <= state_r[4] ? reply_r : 32'h0;
          default: hrdata <= 32'h0;
        endcase
      end
      if (wr_r && state_r[0])
      begin
        case (wa_r)
          `SQI_OFS_ARG1: a1_r <= hwdata[15:0];
          `SQI_OFS_ARG2: a2_r <= hwdata[15:0];
          `SQI_OFS_CMD:
          begin
            op_r <= hwdata[7:0];
            get_r <= hwdata[`SQI_CMD_GET];
            na_r <= hwdata[`SQI_CMD_NA +: 2];
            err_r <= 1'b0;
            done_r <= 1'b0;
            state_r <= S_CHK;
          end
          default: ;
        endcase
      end
      case (state_r)
        S_IDLE: ;
        S_CHK:
        begin
          if (err_w)
          begin
            err_r <= 1'b1;
            done_r <= 1'b1;
            state_r <= S_IDLE;
          end
          else if (!get_r)
          begin
            case (op_r)
              `SQI_OP_AOFS:
                if (a1_r == 16'h0)
                  analog_offset <= {4{a2_r}};
                else
                  analog_offset[{fsel, 4'h0} +: 16] <= a2_r;
              `SQI_OP_GAIN:
                if (a1_r == 16'h0)
                  gain_r <= {4{a2_r}};
                else
                  gain_r[{fsel, 4'h0} +: 16] <= a2_r;
              `SQI_OP_GREF: gref_r <= a1_r;
              `SQI_OP_SAMP: line_samples <= a1_r[10:0];
              `SQI_OP_EOLS: eol_stats_en <= a1_r[0];
              `SQI_OP_CEN:
              begin
                fixed_pattern_correction_en <= a1_r[0];
                response_nonuniformity_correction_en <= a2_r[0];
              end
              default: ;
            endcase
            done_r <= 1'b1;
            state_r <= S_IDLE;
          end
          else if (is_pix(op_r))
          begin
            cur_r <= a1_r;
            last_r <= (op_r == `SQI_OP_FPONE || a2_r <= a1_r) ? a1_r : a2_r;
            sum_r <= 32'h0;
            n_r <= 16'h0;
            case (op_r)
              `SQI_OP_FPRNG, `SQI_OP_FPONE: pix_sel <= `SQI_SEL_FP;
              `SQI_OP_RNRNG: pix_sel <= `SQI_SEL_RN;
              default: pix_sel <= `SQI_SEL_RAW;
            endcase
            state_r <= S_RD;
          end
          else
          begin
            idx_r <= 16'h0;
            cnt_r <= nwords;
            reply_r <= word;
            state_r <= S_PUT;
          end
        end
        S_RD:
        begin
          pix_rd <= 1'b1;
          pix_addr <= cur_r[12:0];
          state_r <= S_WT;
        end
        S_WT:
        begin
          if (op_r == `SQI_OP_PIXAVG)
          begin
            sum_r <= sum_r + {16'h0, pix_data};
            n_r <= n_r + 16'h1;
            if (cur_r == last_r)
            begin
              rem_r <= 32'h0;
              dcnt_r <= 6'h0;
              state_r <= S_DIV;
            end
            else
            begin
              cur_r <= cur_r + 16'h1;
              state_r <= S_RD;
            end
          end
          else
          begin
            reply_r <= {16'h0, pix_data};
            state_r <= S_PUT;
          end
        end
        S_DIV:
        begin
          sum_r <= {sum_r[30:0], ge};
          rem_r <= ge ? rem2 - {16'h0, n_r} : rem2;
          dcnt_r <= dcnt_r + 6'h1;
          if (dcnt_r == 6'h1f)
          begin
            reply_r <= {sum_r[30:0], ge};
            cur_r <= last_r;
            state_r <= S_PUT;
          end
        end
        S_PUT:
          if (pop)
          begin
            if (is_pix(op_r) && cur_r != last_r)
            begin
              cur_r <= cur_r + 16'h1;
              state_r <= S_RD;
            end
            else if (!is_pix(op_r) && idx_r + 16'h1 < cnt_r)
            begin
              idx_r <= idx_r + 16'h1;
              reply_r <= word;
            end
            else
            begin
              done_r <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // sqi_top

/* sqi_props.sv */
// checker of the sqi_top ports
// assumes a bind into sqi_top, one clock, synchronous low reset
`include "sqi_map.vh"
module sqi_props (
  // clock and reset
  input wire clk,
  input wire resetn,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // pixel port
  input wire pix_rd,
  input wire [1:0] pix_sel,
  input wire [12:0] pix_addr,
  // settings
  input wire fixed_pattern_correction_en,
  input wire response_nonuniformity_correction_en,
  input wire eol_stats_en,
  input wire [10:0] line_samples,
  input wire [63:0] analog_offset,
  input wire [63:0] gain_total
);
  timeunit 1ns;
  timeprecision 1ps;
  reg wr_r;
  reg unm_r;
  reg [3:0] ago_r;
  // =====
  // cycles since a write data phase
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_r <= 1'b0;
      unm_r <= 1'b0;
      ago_r <= 4'hf;
    end
    else
    begin
      wr_r <= hsel && htrans[1] && hready && hwrite;
      unm_r <= hsel && htrans[1] && hready && !hwrite && haddr[7:0] == 8'h20;
      ago_r <= wr_r ? 4'h0 : ago_r + {3'h0, ago_r != 4'hf};
    end
  end
  // =====
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_reset_values: assert property (!$past(resetn) |-> line_samples == `SQI_SAMP_RST &&
    analog_offset == 64'h0 && gain_total == 64'h0 && !fixed_pattern_correction_en)
    else $error("settings not at reset values");
  a_samples_legal: assert property (line_samples inside {`SQI_SAMP_A, `SQI_SAMP_B, `SQI_SAMP_RST})
    else $error("illegal sample count");
  a_enables_quiet: assert property ($past(resetn) && !$stable({fixed_pattern_correction_en,
    response_nonuniformity_correction_en, eol_stats_en}) |-> ago_r <= 4'h6)
    else $error("enable changed without a command");
  a_values_quiet: assert property ($past(resetn) && ($changed(line_samples) || $changed(analog_offset)
    || $changed(gain_total)) |-> ago_r <= 4'h7) else $error("setting changed without a command");
  a_pixel_pulse: assert property (pix_rd |=> !pix_rd) else $error("pixel request too long");
  a_pixel_source: assert property (pix_rd |-> pix_sel != 2'h3 && pix_addr != 13'h0)
    else $error("bad pixel request");
  a_unmapped_zero: assert property (unm_r |-> hrdata == 32'h0) else $error("unmapped read not zero");
  c_fp_read: cover property (pix_rd && pix_sel == `SQI_SEL_FP);
  c_small_count: cover property (line_samples == `SQI_SAMP_A);
  c_fp_on: cover property ($rose(fixed_pattern_correction_en));
endmodule // sqi_props

/* sqi_pix_model.sv */
// pixel source beside sqi_top
// answers in the request cycle, toggles between requests
module sqi_pix_model (
  // clock
  input wire clk,
  // request
  input wire pix_rd,
  input wire [1:0] pix_sel,
  input wire [12:0] pix_addr,
  // answer
  output logic [15:0] pix_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_r = 16'h0;
  always_comb
    pix_data = pix_rd ? ({1'b0, pix_sel, pix_addr} ^ 16'h2c00) : ~last_r;
  always @(posedge clk)
    last_r <= pix_data;
endmodule // sqi_pix_model

/* tb_settings_query_interpreter.sv */
// testbench of sqi_top: bus host, model, checks
// assumes sqi_pix_model and sqi_props beside it
`include "sqi_map.vh"
module tb_settings_query_interpreter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] M_ID = 32'h0000_1234; // arbitrary value
  localparam logic [31:0] S_ID = 32'h0000_5678; // arbitrary value
  localparam logic [31:0] V_ID = 32'h0000_9abc; // arbitrary value
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] ctl = 4'h0;
  logic [31:0] lfsr = 32'h79e4;
  logic [31:0] rd;
  logic [31:0] st;
  wire hready;
  wire [31:0] hrdata;
  wire hresp;
  wire pix_rd;
  wire [1:0] pix_sel;
  wire [12:0] pix_addr;
  wire [15:0] pix_data;
  wire fp_en;
  wire rn_en;
  wire eol;
  wire [10:0] samp;
  wire [63:0] ofs;
  wire [63:0] gain;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] last;
  int s0;
  int e;
  int m_samp = 1024;
  int m_eol = 0;
  int m_fp = 0;
  int m_rn = 0;
  int m_ref = 0;
  int m_ofs [1:4] = '{0, 0, 0, 0};
  int m_gn [1:4] = '{0, 0, 0, 0};
  int q [$];
  sqi_top #(.GATE_CYC(32'd100), .MODEL_ID(M_ID), .SERIAL_ID(S_ID), .VERSION_ID(V_ID)) sqi_top_inst (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .ctl_line(ctl),
    .pix_rd(pix_rd), .pix_sel(pix_sel), .pix_addr(pix_addr), .pix_data(pix_data), .fixed_pattern_correction_en(fp_en),
    .response_nonuniformity_correction_en(rn_en), .eol_stats_en(eol), .line_samples(samp), .analog_offset(ofs),
    .gain_total(gain));
  sqi_pix_model sqi_pix_model_inst (.clk(clk), .pix_rd(pix_rd), .pix_sel(pix_sel), .pix_addr(pix_addr),
    .pix_data(pix_data));
  initial
  begin
    forever #5 clk = ~clk;
  end
  // line sync at 1/8, forward at 1/16 of the clock
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ctl <= {1'b0, cyc[3], 1'b0, cyc[2]};
  end
  // =====
  // helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic poll();
    int k;
    k = 0;
    do
    begin
      bus(`SQI_OFS_STAT, 1'b0, 32'h0, st);
      k++;
    end
    while (st[`SQI_ST_VALID] !== 1'b1 && st[`SQI_ST_DONE] !== 1'b1 && k < 300);
  endtask
  // =====
  // model, command and reply comparison
  task automatic run(input logic [7:0] op, input bit get, input int na, input int a1, input int a2, input string nm);
    bit err;
    int s;
    int hi;
    int sum;
    err = 1'b0;
    sum = 0;
    q.delete();
    s = (op == `SQI_OP_FPRNG || op == `SQI_OP_FPONE) ? 1 : op == `SQI_OP_RNRNG ? 2 : 0;
    hi = (op == `SQI_OP_FPONE || a2 <= a1) ? a1 : a2;
    case (op)
      `SQI_OP_AOFS, `SQI_OP_GAIN, `SQI_OP_TGAIN:
      begin
        err = na < 1 || a1 > 4 || (!get && (na < 2 || op == `SQI_OP_TGAIN));
        for (int t = 1; t <= 4; t++)
        begin
          if (!err && get && (a1 == 0 || a1 == t))
            q.push_back(op == `SQI_OP_AOFS ? m_ofs[t] : op == `SQI_OP_GAIN ? m_gn[t] : m_gn[t] + m_ref);
          if (!err && !get && (a1 == 0 || a1 == t) && op == `SQI_OP_AOFS)
            m_ofs[t] = a2;
          if (!err && !get && (a1 == 0 || a1 == t) && op == `SQI_OP_GAIN)
            m_gn[t] = a2;
        end
      end
      `SQI_OP_FPRNG, `SQI_OP_RNRNG, `SQI_OP_PIXV, `SQI_OP_PIXAVG, `SQI_OP_FPONE:
      begin
        err = !get || a1 == 0 || na < (op == `SQI_OP_FPONE ? 1 : 2);
        for (int x = a1; x <= hi && !err; x++)
        begin
          sum += {s[1:0], x[12:0]} ^ 16'h2c00;
          if (op != `SQI_OP_PIXAVG)
            q.push_back({s[1:0], x[12:0]} ^ 16'h2c00);
        end
        if (!err && op == `SQI_OP_PIXAVG)
          q.push_back(sum / (hi - a1 + 1));
      end
      `SQI_OP_SAMP, `SQI_OP_EOLS, `SQI_OP_GREF:
      begin
        err = !get && (na < 1 || (op == `SQI_OP_SAMP && !(a1 inside {256, 512, 1024})));
        if (get)
          q.push_back(op == `SQI_OP_SAMP ? m_samp : op == `SQI_OP_EOLS ? m_eol : m_ref);
        if (!err && !get && op == `SQI_OP_SAMP)
          m_samp = a1;
        if (!err && !get && op == `SQI_OP_EOLS)
          m_eol = a1;
        if (!err && !get && op == `SQI_OP_GREF)
          m_ref = a1;
      end
      `SQI_OP_CEN:
      begin
        err = !get && na < 2;
        if (get)
          q = '{m_fp, m_rn};
        if (!err && !get)
          m_fp = a1;
        if (!err && !get)
          m_rn = a2;
      end
      `SQI_OP_LINK, `SQI_OP_MODEL, `SQI_OP_SERIAL, `SQI_OP_VER, `SQI_OP_HELP:
      begin
        err = !get;
        for (int k = 1; k <= 17 && get && op == `SQI_OP_HELP; k++)
          q.push_back(k);
        if (get && op != `SQI_OP_HELP)
          q.push_back(op == `SQI_OP_LINK ? `SQI_LINK_WORD : op == `SQI_OP_MODEL ? M_ID : op == `SQI_OP_SERIAL ? S_ID : V_ID);
      end
      `SQI_OP_FREQ:
      begin
        err = !get || na < 1 || a1 < 1 || a1 > 4;
        if (!err)
          q.push_back(-1);
      end
      default:
        err = 1'b1;
    endcase
    bus(`SQI_OFS_ARG1, 1'b1, 32'(a1), rd);
    bus(`SQI_OFS_ARG2, 1'b1, 32'(a2), rd);
    bus(`SQI_OFS_CMD, 1'b1, {21'h0, 2'(na), get, op}, rd);
    foreach (q[i])
    begin
      poll();
      bus(`SQI_OFS_REPLY, 1'b0, 32'h0, rd);
      last = rd;
      if (q[i] != -1)
        chk(nm, rd, q[i]);
    end
    poll();
    chk(nm, {31'h0, st[`SQI_ST_ERR]}, {31'h0, err});
  endtask
  // =====
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("samples", 32'(samp), 32'd1024);
    for (int i = 4; i <= 10; i++)
      run(i[7:0], 1'b1, 0, 0, 0, "query");
    run(`SQI_OP_HELP, 1'b1, 0, 0, 0, "help");
    $display("test reset values done");
    run(`SQI_OP_SAMP, 1'b0, 1, 256, 0, "samples set");
    run(`SQI_OP_SAMP, 1'b0, 1, 300, 0, "samples bad");
    run(`SQI_OP_SAMP, 1'b1, 0, 0, 0, "samples get");
    run(`SQI_OP_EOLS, 1'b0, 1, 1, 0, "eol set");
    run(`SQI_OP_EOLS, 1'b1, 0, 0, 0, "eol get");
    for (int i = 0; i < 2; i++)
    begin
      run(`SQI_OP_CEN, 1'b0, 2, 1 - i, i, "enables set");
      run(`SQI_OP_CEN, 1'b1, 0, 0, 0, "enables get");
      chk("ports", 32'({samp, eol, fp_en, rn_en}), 32'({m_samp[10:0], m_eol[0], m_fp[0], m_rn[0]}));
    end
    $display("test settings done");
    for (int t = 0; t <= 4; t++)
    begin
      run(`SQI_OP_AOFS, 1'b0, 2, t, int'(rnd() & 32'hffff), "offset set");
      run(`SQI_OP_GAIN, 1'b0, 2, 4 - t, int'(rnd() & 32'hff), "gain set");
    end
    run(`SQI_OP_GREF, 1'b0, 1, int'(rnd() & 32'hff), 0, "ref set");
    run(`SQI_OP_GREF, 1'b1, 0, 0, 0, "ref get");
    run(`SQI_OP_GAIN, 1'b1, 1, 0, 0, "gain get");
    for (int t = 0; t <= 4; t++)
    begin
      run(`SQI_OP_AOFS, 1'b1, 1, t, 0, "offset get");
      run(`SQI_OP_TGAIN, 1'b1, 1, t, 0, "total gain");
    end
    for (int t = 1; t <= 4; t++)
      chk("gain ports", {ofs[16*t-16 +: 16], gain[16*t-16 +: 16]}, {m_ofs[t][15:0], 16'(m_gn[t] + m_ref)});
    $display("test gains done");
    s0 = int'(rnd() % 32'd50) + 1;
    run(`SQI_OP_FPRNG, 1'b1, 2, s0, s0 + 3, "fp range");
    run(`SQI_OP_RNRNG, 1'b1, 2, s0, s0, "rn range");
    run(`SQI_OP_PIXV, 1'b1, 2, 8190, 8191, "pixels");
    run(`SQI_OP_PIXAVG, 1'b1, 2, s0, s0 + 5, "average");
    run(`SQI_OP_FPONE, 1'b1, 1, s0, 0, "fp one");
    $display("test pixels done");
    run(8'h30, 1'b1, 0, 0, 0, "bad opcode");
    run(`SQI_OP_AOFS, 1'b1, 0, 1, 0, "no tap");
    run(`SQI_OP_AOFS, 1'b1, 1, 5, 0, "tap 5");
    run(`SQI_OP_FREQ, 1'b1, 1, 0, 0, "selector 0");
    run(`SQI_OP_FREQ, 1'b1, 1, 5, 0, "selector 5");
    run(`SQI_OP_FPRNG, 1'b1, 2, 0, 4, "pixel 0");
    run(`SQI_OP_MODEL, 1'b0, 1, 1, 0, "model set");
    run(`SQI_OP_AOFS, 1'b0, 1, 2, 0, "no value");
    run(`SQI_OP_AOFS, 1'b1, 1, 0, 0, "offset kept");
    bus(`SQI_OFS_REPLY, 1'b0, 32'h0, rd);
    chk("empty reply", rd, 32'h0);
    bus(8'h20, 1'b1, rnd(), rd);
    bus(8'h20, 1'b0, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    $display("test errors done");
    for (int i = 1; i <= 4; i++)
    begin
      e = i == 1 ? 12000 : i == 3 ? 6000 : 0;
      run(`SQI_OP_FREQ, 1'b1, 1, i, 0, "frequency");
      chk("frequency", 32'(last == e || last == e + (e > 0 ? 1000 : 0)), 32'h1);
    end
    $display("test frequency done");
    complete_run();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired");
    complete_run();
  end
endmodule // tb_settings_query_interpreter

bind sqi_top sqi_props sqi_props_inst (
  .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix_rd(pix_rd), .pix_sel(pix_sel), .pix_addr(pix_addr),
  .fixed_pattern_correction_en(fixed_pattern_correction_en),
  .response_nonuniformity_correction_en(response_nonuniformity_correction_en), .eol_stats_en(eol_stats_en),
  .line_samples(line_samples), .analog_offset(analog_offset), .gain_total(gain_total));
